//--- psio_top.sv
/*
 * port pins 1 to 3: clear pulses, protection or output-off status,
 * or general input/output with pwm; apb registers.
 * assumes protection and switch state arrive on this clock, while pin
 * levels arrive asynchronously with a pull-up.
 */
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
module psio_top #(
    parameter int PULSE_CYC = psio_pkg::MIN_LOW_CYC,
    parameter int QUAL_W = 16,
    parameter int PWM_W = 32
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // instrument state
    input wire logic prot_active_i,
    input wire logic output_on_i,
    output logic prot_clear_o,
    // port pins 1 to 3, index 0 is pin 1
    input wire logic [2:0] pin_i,
    output logic [2:0] pin_o,
    output logic [2:0] pin_oe_o
);

    localparam int NPIN = 3;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // digital 1 is a low level; inversion flips the level
    function automatic logic pin_level(input logic d, input logic inv);
        pin_level = ~d ^ inv;
    endfunction

    // index within a group of three words, or 3 outside it
    function automatic logic [1:0] grp_idx(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] off;
        off = a - base;
        if (off[1:0] == 2'h0 && off < 8'h0c) begin
            grp_idx = off[3:2];
        end else begin
            grp_idx = 2'h3;
        end
    endfunction

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [psio_pkg::CTRL_W-1:0] ctrl_reg [NPIN];
    logic [PWM_W-1:0] period_reg [NPIN];
    logic [PWM_W-1:0] duty_reg [NPIN];
    logic [QUAL_W-1:0] qual_reg;
    logic [1:0] evt_reg;
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [QUAL_W-1:0] low_cnt_reg;
    logic qual_done_reg;
    logic on_d_reg;
    logic [15:0] pulse_cnt_reg;
    logic pulsing_reg;
    logic [2:0] pwm_act;
    logic [2:0] in_state;
    logic [2:0] inv;
    logic [1:0] mode [NPIN];
    logic [1:0] val [NPIN];
    logic wr_en;
    logic rd_en;
    logic [1:0] i_ctrl;
    logic [1:0] i_per;
    logic [1:0] i_duty;
    logic mapped;
    logic clear_hit;
    logic pulse_start;
    logic [31:0] rd_word;

    // ****************************************************************
    // field decode
    // ****************************************************************
    always_comb begin
        for (int n = 0; n < NPIN; n++) begin
            mode[n] = ctrl_reg[n][psio_pkg::CTRL_MODE_LSB +: 2];
            val[n] = ctrl_reg[n][psio_pkg::CTRL_VAL_LSB +: 2];
            inv[n] = ctrl_reg[n][psio_pkg::CTRL_INV_BIT];
        end
    end

    // ****************************************************************
    // apb decode
    // ****************************************************************
    // no wait states: each access ends in its first access cycle
    assign pready_o = 1'b1;
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign rd_en = psel_i && !penable_i && !pwrite_i;
    assign i_ctrl = grp_idx(paddr_i, psio_pkg::ADDR_PIN_CTRL);
    assign i_per = grp_idx(paddr_i, psio_pkg::ADDR_PWM_PERIOD);
    assign i_duty = grp_idx(paddr_i, psio_pkg::ADDR_PWM_DUTY);
    assign mapped = i_ctrl != 2'h3 || i_per != 2'h3 || i_duty != 2'h3 ||
                    paddr_i == psio_pkg::ADDR_QUAL ||
                    paddr_i == psio_pkg::ADDR_STATUS ||
                    paddr_i == psio_pkg::ADDR_EVENT;

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    // pin control words
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int n = 0; n < NPIN; n++) begin
                ctrl_reg[n] <= psio_pkg::CTRL_RESET;
            end
        end else if (wr_en && i_ctrl != 2'h3) begin
            ctrl_reg[i_ctrl] <= pwdata_i[psio_pkg::CTRL_W-1:0];
        end
    end

    // pwm period and duty, kept as separate settings
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int n = 0; n < NPIN; n++) begin
                period_reg[n] <= psio_pkg::PWM_RESET[PWM_W-1:0];
                duty_reg[n] <= psio_pkg::PWM_RESET[PWM_W-1:0];
            end
        end else if (wr_en) begin
            if (i_per != 2'h3) begin
                period_reg[i_per] <= pwdata_i[PWM_W-1:0];
            end
            if (i_duty != 2'h3) begin
                duty_reg[i_duty] <= pwdata_i[PWM_W-1:0];
            end
        end
    end

    // qualification length, reset to the minimum pulse width
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            qual_reg <= QUAL_W'(PULSE_CYC);
        end else if (wr_en && paddr_i == psio_pkg::ADDR_QUAL) begin
            qual_reg <= pwdata_i[QUAL_W-1:0];
        end
    end

    // sticky events, write one to clear; a new event beats the clear
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            evt_reg <= 2'h0;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if ((b == psio_pkg::EVT_CLEAR_BIT && clear_hit) ||
                    (b == psio_pkg::EVT_SENT_BIT && pulse_start)) begin
                    evt_reg[b] <= 1'b1;
                end else if (wr_en && paddr_i == psio_pkg::ADDR_EVENT && pwdata_i[b]) begin
                    evt_reg[b] <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    always_comb begin
        rd_word = 32'h00000000;
        if (i_ctrl != 2'h3) begin
            rd_word[psio_pkg::CTRL_W-1:0] = ctrl_reg[i_ctrl];
        end else if (i_per != 2'h3) begin
            rd_word[PWM_W-1:0] = period_reg[i_per];
        end else if (i_duty != 2'h3) begin
            rd_word[PWM_W-1:0] = duty_reg[i_duty];
        end else if (paddr_i == psio_pkg::ADDR_QUAL) begin
            rd_word[QUAL_W-1:0] = qual_reg;
        end else if (paddr_i == psio_pkg::ADDR_STATUS) begin
            rd_word[psio_pkg::STAT_IN_LSB +: 3] = in_state;
            rd_word[psio_pkg::STAT_PROT_BIT] = prot_active_i;
            rd_word[psio_pkg::STAT_ON_BIT] = output_on_i;
            rd_word[psio_pkg::STAT_PULSE_BIT] = pulsing_reg;
        end else if (paddr_i == psio_pkg::ADDR_EVENT) begin
            rd_word[1:0] = evt_reg;
        end
    end

    // read data captured in setup so it stands through the access cycle
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prdata_o <= 32'h00000000;
        end else if (rd_en) begin
            prdata_o <= rd_word;
        end
    end

    // unmapped addresses answer with an error, writes there are dropped
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pslverr_o <= 1'b0;
        end else if (psel_i && !penable_i) begin
            pslverr_o <= !mapped;
        end
    end

    // ****************************************************************
    // pin input synchroniser
    // ****************************************************************
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_reg <= 3'h7;
            sync2_reg <= 3'h7;
        end else begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
        end
    end

    // high reads as 1 unless inverted; an open pin pulled up reads 1
    assign in_state = sync2_reg ^ inv;

    // ****************************************************************
    // pin 1 pulse input qualification
    // ****************************************************************
    // a pulse is input state 0 held for qual_reg cycles;
    // our own outgoing pulse is masked so it cannot clear us
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_cnt_reg <= '0;
            qual_done_reg <= 1'b0;
        end else if (mode[0] != psio_pkg::MODE_DEFAULT || pulsing_reg || in_state[0]) begin
            low_cnt_reg <= '0;
            qual_done_reg <= 1'b0;
        end else if (!qual_done_reg) begin
            if (low_cnt_reg + 1'b1 >= qual_reg) begin
                qual_done_reg <= 1'b1;
            end
            low_cnt_reg <= low_cnt_reg + 1'b1;
        end
    end

    // one clear per pulse, at the cycle the width is reached
    assign clear_hit = mode[0] == psio_pkg::MODE_DEFAULT && !pulsing_reg && !in_state[0] &&
                       !qual_done_reg && low_cnt_reg + 1'b1 >= qual_reg && prot_active_i;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prot_clear_o <= 1'b0;
        end else begin
            prot_clear_o <= clear_hit;
        end
    end

    // ****************************************************************
    // pin 1 pulse output
    // ****************************************************************
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            on_d_reg <= 1'b0;
        end else begin
            on_d_reg <= output_on_i;
        end
    end

    // off to on with protection released starts one pulse
    assign pulse_start = mode[0] == psio_pkg::MODE_DEFAULT && output_on_i && !on_d_reg &&
                         !prot_active_i && !pulsing_reg;

    // the pulse runs its full width even if the switch turns off again
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pulsing_reg <= 1'b0;
            pulse_cnt_reg <= 16'h0000;
        end else if (pulse_start) begin
            pulsing_reg <= 1'b1;
            pulse_cnt_reg <= 16'(PULSE_CYC - 1);
        end else if (pulsing_reg) begin
            if (pulse_cnt_reg == 16'h0000 || mode[0] != psio_pkg::MODE_DEFAULT) begin
                pulsing_reg <= 1'b0;
            end else begin
                pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
            end
        end
    end

    // ****************************************************************
    // pwm generators
    // ****************************************************************
    for (genvar g = 0; g < NPIN; g++) begin : g_pwm
        psio_pwm #(
            .W(PWM_W)
        ) u_pwm (
            .mclk_i(mclk_i),
            .resetn_i(resetn_i),
            .enable_i(mode[g] == psio_pkg::MODE_OUTPUT && val[g] == psio_pkg::VAL_PWM),
            .period_i(period_reg[g]),
            .duty_i(duty_reg[g]),
            .active_o(pwm_act[g])
        );
    end

    // ****************************************************************
    // pin drivers
    // ****************************************************************
    // registered so pin levels never glitch on decode changes
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_o <= 3'h7;
            pin_oe_o <= 3'h0;
        end else begin
            for (int n = 0; n < NPIN; n++) begin
                case (mode[n])
                    psio_pkg::MODE_DEFAULT: begin
                        if (n == 0) begin
                            // released between pulses so the far end can pulse us
                            pin_o[n] <= pin_level(1'b1, inv[n]);
                            pin_oe_o[n] <= pulsing_reg;
                        end else if (n == 1) begin
                            pin_o[n] <= pin_level(prot_active_i, inv[n]);
                            pin_oe_o[n] <= 1'b1;
                        end else begin
                            pin_o[n] <= pin_level(output_on_i, inv[n]);
                            pin_oe_o[n] <= 1'b1;
                        end
                    end
                    psio_pkg::MODE_OUTPUT: begin
                        case (val[n])
                            psio_pkg::VAL_TRUE: pin_o[n] <= pin_level(1'b1, inv[n]);
                            psio_pkg::VAL_PWM: pin_o[n] <= pin_level(pwm_act[n], inv[n]);
                            default: pin_o[n] <= pin_level(1'b0, inv[n]);
                        endcase
                        pin_oe_o[n] <= 1'b1;
                    end
                    default: begin
                        // input mode and unused codes leave the pin to the outside
                        pin_o[n] <= pin_level(1'b0, inv[n]);
                        pin_oe_o[n] <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

//--- psio_pkg.sv
/*
 * constants, register map and field layout of the protection status i/o pins.
 * assumes one 250 mhz clock and an apb master with 32-bit data.
 */
// Behaviour
// - every pin has an invert bit acting on both input and output direction
// - output true drives low, or high when inverted
// - output false drives high, or low when inverted
// - pwm output uses separate per-pin period and duty settings
// - input mode samples the pin and reports it, applying inversion
// - pin 1 clear function both receives and sends pulses
// - a qualified pulse on pin 1 clears an active protection
// - output switching on after protection release sends one pulse on pin 1
// - pulses keep their low level for at least 30 us
// - pin 2 status: high when unprotected, low when protected
// - inverted status pins drive the exact opposite level
// - pin 3 status: high when output off, low when on
// - pulses are active low: high, then low, then high again; with pin 1 inverted the code drives high pulses and qualifies a high level
// - an open input reads 1, or 0 when inverted
package psio_pkg;

    // ********************************
    // timing
    // ********************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int MIN_LOW_NS = 30000;
    // least time, so round up
    localparam int MIN_LOW_CYC = (MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ********************************
    // register byte addresses
    // ********************************
    localparam logic [7:0] ADDR_PIN_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PWM_PERIOD = 8'h10;
    localparam logic [7:0] ADDR_PWM_DUTY = 8'h20;
    localparam logic [7:0] ADDR_QUAL = 8'h30;
    localparam logic [7:0] ADDR_STATUS = 8'h34;
    localparam logic [7:0] ADDR_EVENT = 8'h38;

    // ********************************
    // pin control fields
    // ********************************
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_INV_BIT = 2;
    localparam int CTRL_VAL_LSB = 3;
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // pin mode encodings
    localparam logic [1:0] MODE_DEFAULT = 2'h0;
    localparam logic [1:0] MODE_INPUT = 2'h1;
    localparam logic [1:0] MODE_OUTPUT = 2'h2;

    // output value encodings
    localparam logic [1:0] VAL_FALSE = 2'h0;
    localparam logic [1:0] VAL_TRUE = 2'h1;
    localparam logic [1:0] VAL_PWM = 2'h2;

    // ********************************
    // status and event fields
    // ********************************
    localparam int STAT_IN_LSB = 0;
    localparam int STAT_PROT_BIT = 3;
    localparam int STAT_ON_BIT = 4;
    localparam int STAT_PULSE_BIT = 5;
    localparam int EVT_CLEAR_BIT = 0;
    localparam int EVT_SENT_BIT = 1;
    localparam logic [31:0] PWM_RESET = 32'h00000000;

endpackage

//--- psio_pwm.sv
/*
 * one pwm generator: counts a period and flags the active part of it.
 * assumes period and duty are stable registers on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module psio_pwm #(
    parameter int W = 32
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // settings
    input wire logic enable_i,
    input wire logic [W-1:0] period_i,
    input wire logic [W-1:0] duty_i,
    // result
    output logic active_o
);

    logic [W-1:0] cnt_reg;

    // ****************************************************************
    // period counter
    // ****************************************************************
    // a period of zero parks the counter so the output stays idle
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_reg <= '0;
        end else if (!enable_i || period_i == '0 || cnt_reg >= period_i - 1'b1) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // active for duty cycles out of each period
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            active_o <= 1'b0;
        end else begin
            active_o <= enable_i && period_i != '0 && cnt_reg < duty_i;
        end
    end

endmodule
`default_nettype wire

//--- psio_ext.sv
/* external instrument on pins 1 to 3: levels or pulses, else a pull-up.
   assumes the device clock and sees the device's drive. */
`timescale 1ns/1ps
`default_nettype none
module psio_ext (
    // clock
    input wire logic mclk_i,
    // device side of the pins
    input wire logic [2:0] pin_o_i,
    input wire logic [2:0] pin_oe_i,
    // resolved wire level
    output logic [2:0] pin_lvl_o
);
    logic [2:0] drv = 3'h0;
    logic [2:0] val = 3'h7;
    // device drive wins, then ours; an open pin floats high on the pull-up
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_lvl_o[i] = pin_oe_i[i] ? pin_o_i[i] : (drv[i] ? val[i] : 1'b1);
        end
    end
    // high, low for the asked count, high again, then let go
    task automatic pulse(input int pin, input int low_cyc);
        @(posedge mclk_i);
        drv[pin] <= 1'b1;
        val[pin] <= 1'b0;
        repeat (low_cyc) @(posedge mclk_i);
        val[pin] <= 1'b1;
        @(posedge mclk_i);
        drv[pin] <= 1'b0;
    endtask
    // hold a level, or release the pin when on is low
    task automatic level(input int pin, input logic v, input logic on);
        drv[pin] <= on;
        val[pin] <= v;
    endtask
endmodule
`default_nettype wire

//--- psio_top_properties.sv
/* timing properties of pin 1 pulses and the clear request.
   assumes pin 1 stays in its default function while the switch toggles. */
`timescale 1ns/1ps
`default_nettype none
module psio_top_properties #(
    parameter int PULSE_CYC = 20
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // watched ports
    input wire logic pready_o,
    input wire logic prot_active_i,
    input wire logic output_on_i,
    input wire logic prot_clear_o,
    input wire logic [2:0] pin_i,
    input wire logic [2:0] pin_o,
    input wire logic [2:0] pin_oe_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    logic [31:0] drive_cnt;
    logic [31:0] low_cnt;
    // run lengths of pin 1 driven and pin 1 low, counters avoid long repeats
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            drive_cnt <= 32'h0;
            low_cnt <= 32'h0;
        end else begin
            drive_cnt <= pin_oe_o[0] ? drive_cnt + 32'h1 : 32'h0;
            low_cnt <= !pin_i[0] ? low_cnt + 32'h1 : 32'h0;
        end
    end
    sequence s_switch_on;
        !output_on_i ##1 (output_on_i && !prot_active_i && !pin_oe_o[0]);
    endsequence
    AST_OE1_START: assert property (s_switch_on |-> ##2 (pin_oe_o[0] && !pin_o[0]))
        else $error("pin 1 pulse did not start");
    AST_OE1_LEN: assert property ($fell(pin_oe_o[0]) |-> drive_cnt == PULSE_CYC)
        else $error("pin 1 pulse length wrong");
    AST_OE1_HOLD: assert property ($rose(pin_oe_o[0]) |=> (pin_oe_o[0] && !pin_o[0])[*8])
        else $error("pin 1 pulse not held low");
    AST_CLR_PROT: assert property (prot_clear_o |-> $past(prot_active_i))
        else $error("clear without protection");
    AST_CLR_ONE: assert property (prot_clear_o |=> (!prot_clear_o)[*8])
        else $error("clear request not single");
    AST_CLR_QUAL: assert property (prot_clear_o |-> low_cnt >= PULSE_CYC)
        else $error("clear from short pulse");
    AST_CLR_NOT_OWN: assert property (prot_clear_o |-> !$past(pin_oe_o[0]))
        else $error("clear from own pulse");
    AST_READY: assert property (pready_o)
        else $error("apb not ready");
endmodule
bind psio_top psio_top_properties #(.PULSE_CYC(PULSE_CYC)) u_props (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .pready_o(pready_o),
    .prot_active_i(prot_active_i), .output_on_i(output_on_i),
    .prot_clear_o(prot_clear_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
`default_nettype wire

//--- protection_status_io_pins_bench.sv
/* self-checking bench: apb tasks and one task per scenario.
   assumes psio_top with a short pulse count and the model psio_ext. */
`timescale 1ns/1ps
`default_nettype none
module protection_status_io_pins_bench;
    // ****************
    // clock, reset and wiring
    // ****************
    localparam int PC = 20;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic prot_active_i = 1'b0;
    logic output_on_i = 1'b0;
    logic prot_clear_o;
    logic [2:0] pin_i;
    logic [2:0] pin_o;
    logic [2:0] pin_oe_o;
    int num_errors = 0;
    int checked = 0;
    logic [31:0] rv;
    logic er;
    int n;
    always #2 mclk_i = ~mclk_i;
    psio_top #(.PULSE_CYC(PC)) uut (.mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .prot_active_i(prot_active_i), .output_on_i(output_on_i), .prot_clear_o(prot_clear_o),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
    psio_ext ext (.mclk_i(mclk_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe_o), .pin_lvl_o(pin_i));
    // ****************
    // shared tasks
    // ****************
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk_i);
    endtask
    // one apb transfer, then one idle edge between transfers
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge mclk_i);
        end while (pready_o !== 1'b1);
        rv = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    function automatic logic [31:0] ctl(logic [1:0] m, logic inv, logic [1:0] v);
        return {27'h0, v, inv, m};
    endfunction
    // ****************
    // scenarios
    // ****************
    task automatic t_regs();
        logic [7:0] adr[7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'h30, 8'h3c};
        for (int k = 0; k < 7; k++) begin
            apb(1'b0, adr[k], 32'h0);
            chk("reg reset", rv, (k == 5) ? PC : 0);
            chk("slverr", er, k == 6);
        end
        apb(1'b1, 8'h04, 32'hffffffff);
        apb(1'b0, 8'h04, 32'h0);
        chk("ctrl width", rv, 32'h1f);
        apb(1'b1, 8'h04, 32'h0);
    endtask
    task automatic t_status();
        for (int inv = 0; inv < 2; inv++) begin
            apb(1'b1, 8'h04, ctl(psio_pkg::MODE_DEFAULT, inv[0], 2'h0));
            apb(1'b1, 8'h08, ctl(psio_pkg::MODE_DEFAULT, inv[0], 2'h0));
            for (int c = 0; c < 4; c++) begin
                prot_active_i <= c[0];
                output_on_i <= c[1];
                cyc(4);
                chk("pin2 level", pin_o[1], !c[0] ^ inv[0]);
                chk("pin3 level", pin_o[2], !c[1] ^ inv[0]);
                chk("status oe", pin_oe_o[2:1], 2'h3);
            end
        end
    endtask
    task automatic t_gpo();
        for (int inv = 0; inv < 2; inv++) begin
            for (int v = 0; v < 4; v++) begin
                if (v != 2) begin
                    apb(1'b1, 8'h04, ctl(psio_pkg::MODE_OUTPUT, inv[0], v[1:0]));
                    cyc(3);
                    chk("gp out", pin_o[1], (v != 1) ^ inv[0]);
                end
            end
        end
        apb(1'b1, 8'h18, 32'h0000000a);
        apb(1'b1, 8'h28, 32'h00000003);
        for (int inv = 0; inv < 2; inv++) begin
            apb(1'b1, 8'h08, ctl(psio_pkg::MODE_OUTPUT, inv[0], psio_pkg::VAL_PWM));
            cyc(12);
            n = 0;
            repeat (10) begin
                @(posedge mclk_i);
                if (pin_o[2] === inv[0]) n++;
            end
            chk("pwm active", n, 3);
        end
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h08, 32'h0);
    endtask
    task automatic t_gpi();
        for (int inv = 0; inv < 2; inv++) begin
            apb(1'b1, 8'h00, ctl(psio_pkg::MODE_INPUT, inv[0], 2'h0));
            for (int s = 0; s < 3; s++) begin
                ext.level(0, s[0], s < 2);
                cyc(4);
                apb(1'b0, psio_pkg::ADDR_STATUS, 32'h0);
                chk("input state", rv[0], (s != 0) ^ inv[0]);
                chk("input oe", pin_oe_o[0], 1'b0);
            end
        end
        apb(1'b1, 8'h00, 32'h0);
    endtask
    task automatic t_clear();
        int lens[3] = '{2 * PC, PC / 2, 2 * PC};
        for (int k = 0; k < 3; k++) begin
            prot_active_i <= (k != 2);
            n = 0;
            fork
                ext.pulse(0, lens[k]);
                repeat (3 * PC) begin
                    @(posedge mclk_i);
                    if (prot_clear_o === 1'b1) n++;
                end
            join
            chk("clear count", n, k == 0);
        end
        prot_active_i <= 1'b0;
        apb(1'b0, psio_pkg::ADDR_EVENT, 32'h0);
        chk("clear event", rv[0], 1'b1);
        apb(1'b1, psio_pkg::ADDR_EVENT, 32'h00000003);
        apb(1'b0, psio_pkg::ADDR_EVENT, 32'h0);
        chk("event cleared", rv, 32'h0);
    endtask
    task automatic t_out();
        output_on_i <= 1'b0;
        cyc(4);
        output_on_i <= 1'b1;
        cyc(2);
        // sample between edges, where outputs are settled
        @(negedge mclk_i);
        chk("pulse start", {pin_oe_o[0], pin_o[0]}, 2'h2);
        n = 0;
        while (pin_oe_o[0] === 1'b1 && n < 3 * PC) begin
            if (pin_o[0] === 1'b0) n++;
            @(negedge mclk_i);
        end
        chk("pulse width", n, PC);
        cyc(3);
        chk("line back high", pin_i[0], 1'b1);
        apb(1'b0, psio_pkg::ADDR_EVENT, 32'h0);
        chk("sent event", rv[1], 1'b1);
    endtask
    // ****************
    // verdict and main sequence
    // ****************
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // whole run is a few hundred cycles, so this only trips on a hang
    initial begin
        #100000;
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge mclk_i);
        resetn_i <= 1'b1;
        @(posedge mclk_i);
        t_regs();
        $display("registers done");
        t_status();
        $display("status pins done");
        t_gpo();
        $display("general output done");
        t_gpi();
        $display("general input done");
        t_clear();
        $display("clear input done");
        t_out();
        $display("pulse output done");
        stop_test();
    end
endmodule
`default_nettype wire
